// [shared/csif_regs.svh]
// register offsets, masks and reset values of the clock event flag block
`ifndef CSIF_REGS_SVH
`define CSIF_REGS_SVH
`define CSIF_AW          8
`define CSIF_OFS_EN_CLR  8'h00
`define CSIF_OFS_EN_SET  8'h04
`define CSIF_OFS_FLAGS   8'h08
`define CSIF_OFS_STATUS  8'h0c
`define CSIF_OFS_FCLR    8'h10
`define CSIF_FLAGS_RST   32'h0000_0000
`define CSIF_EN_RST      32'h0000_0000
`define CSIF_IMPL_MASK   32'h0003_8fff
`define CSIF_PLL_MASK    32'h0003_8000
`define CSIF_BOD_MASK    32'h0000_0e00
`define CSIF_FLL_MASK    32'h0000_01f0
`define CSIF_OSC_MASK    32'h0000_000f
`define CSIF_STAT_W      18
`define CSIF_BIT_XTAL    0
`define CSIF_RESP_OKAY   2'h0
`define CSIF_RESP_SLVERR 2'h2
`endif

// [shared/csif_pkg.sv]
// types shared by the clock event flag block
`default_nettype none
package csif_pkg;
    typedef logic [31:0] csif_word_t;
    typedef logic [1:0]  csif_resp_t;
    typedef enum logic [0:0] {
        CSIF_W_IDLE = 1'b0,
        CSIF_W_RESP = 1'b1
    } csif_wr_e;
endpackage
`default_nettype wire

// [shared/csif_reg_if.sv]
// register access carrier between bus slave and flag core
`timescale 1ns/10ps
`default_nettype none
interface csif_reg_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic       wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic       rd_hit;
    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_hit, rd_data, rd_hit);
    modport core (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// [design/csif_axil.sv]
// axi4-lite slave front end of the clock event flag block
`timescale 1ns/10ps
`default_nettype none
`include "csif_regs.svh"
module csif_axil
    import csif_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 s_axil_awvalid,
    output logic                      s_axil_awready,
    input  wire logic [`CSIF_AW-1:0]  s_axil_awaddr,
    input  wire logic                 s_axil_wvalid,
    output logic                      s_axil_wready,
    input  wire logic [31:0]          s_axil_wdata,
    input  wire logic [3:0]           s_axil_wstrb,
    output logic                      s_axil_bvalid,
    input  wire logic                 s_axil_bready,
    output logic [1:0]                s_axil_bresp,
    input  wire logic                 s_axil_arvalid,
    output logic                      s_axil_arready,
    input  wire logic [`CSIF_AW-1:0]  s_axil_araddr,
    output logic                      s_axil_rvalid,
    input  wire logic                 s_axil_rready,
    output logic [31:0]               s_axil_rdata,
    output logic [1:0]                s_axil_rresp,
    csif_reg_if.bus                   rif
);
    csif_wr_e   wst_r,     wst_nxt;
    logic       aw_have_r, aw_have_nxt;
    logic       w_have_r,  w_have_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    csif_word_t w_data_r,  w_data_nxt;
    logic [3:0] w_strb_r,  w_strb_nxt;
    csif_resp_t bresp_r,   bresp_nxt;
    logic       rvalid_r,  rvalid_nxt;
    csif_word_t rdata_r,   rdata_nxt;
    csif_resp_t rresp_r,   rresp_nxt;
    logic       go;

    assign s_axil_awready = !aw_have_r && (wst_r == CSIF_W_IDLE);
    assign s_axil_wready  = !w_have_r && (wst_r == CSIF_W_IDLE);
    assign s_axil_bvalid  = (wst_r == CSIF_W_RESP);
    assign s_axil_bresp   = bresp_r;
    assign s_axil_arready = !rvalid_r;
    assign s_axil_rvalid  = rvalid_r;
    assign s_axil_rdata   = rdata_r;
    assign s_axil_rresp   = rresp_r;
    assign go             = aw_have_r && w_have_r && (wst_r == CSIF_W_IDLE);
    assign rif.wr_en      = go;
    assign rif.wr_addr    = aw_addr_r;
    assign rif.wr_data    = w_data_r;
    assign rif.wr_strb    = w_strb_r;
    assign rif.rd_addr    = s_axil_araddr;

    always_comb begin
        wst_nxt     = wst_r;
        aw_have_nxt = aw_have_r | (s_axil_awvalid & s_axil_awready);
        aw_addr_nxt = (s_axil_awvalid & s_axil_awready) ? s_axil_awaddr : aw_addr_r;
        w_have_nxt  = w_have_r | (s_axil_wvalid & s_axil_wready);
        w_data_nxt  = (s_axil_wvalid & s_axil_wready) ? s_axil_wdata : w_data_r;
        w_strb_nxt  = (s_axil_wvalid & s_axil_wready) ? s_axil_wstrb : w_strb_r;
        bresp_nxt   = bresp_r;
        unique case (wst_r)
            CSIF_W_IDLE: begin
                if (go) begin
                    aw_have_nxt = 1'b0;
                    w_have_nxt  = 1'b0;
                    wst_nxt     = CSIF_W_RESP;
                    bresp_nxt   = rif.wr_hit ? `CSIF_RESP_OKAY : `CSIF_RESP_SLVERR;
                end
            end
            CSIF_W_RESP: begin
                if (s_axil_bready) begin
                    wst_nxt = CSIF_W_IDLE;
                end
            end
        endcase
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axil_arvalid && s_axil_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rif.rd_data;
            rresp_nxt  = rif.rd_hit ? `CSIF_RESP_OKAY : `CSIF_RESP_SLVERR;
        end else if (rvalid_r && s_axil_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wst_r     <= CSIF_W_IDLE;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bresp_r   <= `CSIF_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `CSIF_RESP_OKAY;
        end else begin
            wst_r     <= wst_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end
endmodule
`default_nettype wire

// [design/csif_top.sv]
// clock and supply event flags with enables, interrupt output and register bus
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "csif_regs.svh"
module csif_top
    import csif_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire logic [`CSIF_STAT_W-1:0]  power_clock_status,
    input  wire logic [`CSIF_STAT_W-1:0]  fuse_flag_preset,
    output logic                          irq_o,
    input  wire logic                     s_axil_awvalid,
    output logic                          s_axil_awready,
    input  wire logic [`CSIF_AW-1:0]      s_axil_awaddr,
    input  wire logic                     s_axil_wvalid,
    output logic                          s_axil_wready,
    input  wire logic [31:0]              s_axil_wdata,
    input  wire logic [3:0]               s_axil_wstrb,
    output logic                          s_axil_bvalid,
    input  wire logic                     s_axil_bready,
    output logic [1:0]                    s_axil_bresp,
    input  wire logic                     s_axil_arvalid,
    output logic                          s_axil_arready,
    input  wire logic [`CSIF_AW-1:0]      s_axil_araddr,
    output logic                          s_axil_rvalid,
    input  wire logic                     s_axil_rready,
    output logic [31:0]                   s_axil_rdata,
    output logic [1:0]                    s_axil_rresp
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic csif_word_t strb_mask(input logic [3:0] s);
        csif_word_t m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{s[b]}};
        end
        return m;
    endfunction

    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    csif_reg_if rif ();

    csif_axil u_axil (
        .clk            (ref_clk),
        .rst_n          (rst_n),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .rif            (rif)
    );

    // status synchronisers and stable-value edge detection
    logic [`CSIF_STAT_W-1:0] s1_r, s2_r, s3_r;
    logic [`CSIF_STAT_W-1:0] stab_r, stab_nxt;
    csif_word_t              rise_w;

    generate
        for (genvar i = 0; i < `CSIF_STAT_W; i++) begin : g_stat
            // change counts only once the second and third stages agree
            assign stab_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stab_r[i];
        end
    endgenerate

    assign rise_w = {14'h0000, stab_nxt & ~stab_r} & `CSIF_IMPL_MASK;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= 18'h00000;
            s2_r   <= 18'h00000;
            s3_r   <= 18'h00000;
            stab_r <= 18'h00000;
        end else begin
            s1_r   <= power_clock_status;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            stab_r <= stab_nxt;
        end
    end

    // flags, enables and interrupt
    csif_word_t flags_r, flags_nxt;
    csif_word_t en_r,    en_nxt;
    logic       init_r,  init_nxt;
    logic       irq_r,   irq_nxt;
    csif_word_t wmask_w, clr_w, eset_w, eclr_w, keep_w;
    logic       wr_flags_w;

    assign wmask_w    = rif.wr_data & strb_mask(rif.wr_strb) & `CSIF_IMPL_MASK;
    assign wr_flags_w = rif.wr_en && (hit(rif.wr_addr, `CSIF_OFS_FLAGS) ||
                                      hit(rif.wr_addr, `CSIF_OFS_FCLR));
    assign clr_w      = wr_flags_w ? wmask_w : 32'h0000_0000;
    assign eset_w     = (rif.wr_en && hit(rif.wr_addr, `CSIF_OFS_EN_SET)) ? wmask_w
                                                                         : 32'h0000_0000;
    assign eclr_w     = (rif.wr_en && hit(rif.wr_addr, `CSIF_OFS_EN_CLR)) ? wmask_w
                                                                         : 32'h0000_0000;
    assign keep_w     = flags_r & ~clr_w;

    always_comb begin
        init_nxt  = 1'b1;
        flags_nxt = (flags_r & ~clr_w) | rise_w;
        if (!init_r) begin
            // fuse presets are taken once, on the first cycle after reset
            flags_nxt = flags_nxt | ({14'h0000, fuse_flag_preset} & `CSIF_IMPL_MASK);
        end
        en_nxt  = (en_r | eset_w) & ~eclr_w;
        irq_nxt = |(flags_nxt & en_nxt);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= `CSIF_FLAGS_RST;
            en_r    <= `CSIF_EN_RST;
            init_r  <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            en_r    <= en_nxt;
            init_r  <= init_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    // register read and decode
    always_comb begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = 32'h0000_0000;
        if (hit(rif.rd_addr, `CSIF_OFS_EN_CLR) || hit(rif.rd_addr, `CSIF_OFS_EN_SET)) begin
            rif.rd_data = en_r;
        end else if (hit(rif.rd_addr, `CSIF_OFS_FLAGS)) begin
            rif.rd_data = flags_r;
        end else if (hit(rif.rd_addr, `CSIF_OFS_STATUS)) begin
            rif.rd_data = {14'h0000, stab_r} & `CSIF_IMPL_MASK;
        end else if (!hit(rif.rd_addr, `CSIF_OFS_FCLR)) begin
            rif.rd_hit = 1'b0;
        end
    end

    assign rif.wr_hit = hit(rif.wr_addr, `CSIF_OFS_EN_CLR) ||
                        hit(rif.wr_addr, `CSIF_OFS_EN_SET) ||
                        hit(rif.wr_addr, `CSIF_OFS_FLAGS)  ||
                        hit(rif.wr_addr, `CSIF_OFS_STATUS) ||
                        hit(rif.wr_addr, `CSIF_OFS_FCLR);

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_xtal_up;
        !power_clock_status[`CSIF_BIT_XTAL] ##1 power_clock_status[`CSIF_BIT_XTAL] [*5];
    endsequence

    sequence s_xtal_cleared;
        rif.wr_en && hit(rif.wr_addr, `CSIF_OFS_EN_CLR) && eclr_w[`CSIF_BIT_XTAL];
    endsequence

    a_resv_zero: assert property (
        (flags_r & ~`CSIF_IMPL_MASK) == 32'h0000_0000 &&
        (en_r & ~`CSIF_IMPL_MASK) == 32'h0000_0000)
        else $error("reserved flag or enable bit set");

    a_pll_flag_set: assert property (
        (rise_w & `CSIF_PLL_MASK) != 32'h0000_0000 |=>
        (flags_r & $past(rise_w) & `CSIF_PLL_MASK) == ($past(rise_w) & `CSIF_PLL_MASK))
        else $error("pll flag missed its status rise");

    a_bod_flag_set: assert property (
        (rise_w & `CSIF_BOD_MASK) != 32'h0000_0000 |=>
        (flags_r & $past(rise_w) & `CSIF_BOD_MASK) == ($past(rise_w) & `CSIF_BOD_MASK))
        else $error("brown-out flag missed its status rise");

    a_fll_flag_set: assert property (
        (rise_w & `CSIF_FLL_MASK) != 32'h0000_0000 |=>
        (flags_r & $past(rise_w) & `CSIF_FLL_MASK) == ($past(rise_w) & `CSIF_FLL_MASK))
        else $error("fll flag missed its status rise");

    a_osc_flag_set: assert property (
        (rise_w & `CSIF_OSC_MASK) != 32'h0000_0000 |=>
        (flags_r & $past(rise_w) & `CSIF_OSC_MASK) == ($past(rise_w) & `CSIF_OSC_MASK))
        else $error("oscillator flag missed its status rise");

    a_irq_level: assert property (
        irq_o == |(flags_r & en_r))
        else $error("interrupt output disagrees with flags and enables");

    a_w1c_clears: assert property (
        wr_flags_w && init_r && (rise_w & clr_w) == 32'h0000_0000 && clr_w != 32'h0000_0000
        |=> (flags_r & $past(clr_w)) == 32'h0000_0000)
        else $error("write one did not clear flag");

    a_zero_keeps: assert property (
        1'b1 |=> (flags_r & $past(keep_w)) == $past(keep_w))
        else $error("flag lost without a write one");

    a_no_spurious: assert property (
        init_r |=> (flags_r & ~$past(flags_r) & ~$past(rise_w)) == 32'h0000_0000)
        else $error("flag set without a status rise");

    a_fuse_preset: assert property (
        $rose(init_r) |-> (flags_r & ({14'h0000, $past(fuse_flag_preset)} & `CSIF_IMPL_MASK))
                          == ({14'h0000, $past(fuse_flag_preset)} & `CSIF_IMPL_MASK))
        else $error("fuse preset flags not loaded");

    a_enable_set: assert property (
        rif.wr_en && hit(rif.wr_addr, `CSIF_OFS_EN_SET) && wmask_w[`CSIF_BIT_XTAL]
        |=> en_r[`CSIF_BIT_XTAL])
        else $error("enable set write did not set crystal enable");

    a_enable_zero: assert property (
        rif.wr_en && hit(rif.wr_addr, `CSIF_OFS_EN_SET) && !wmask_w[`CSIF_BIT_XTAL]
        |=> en_r[`CSIF_BIT_XTAL] == $past(en_r[`CSIF_BIT_XTAL]))
        else $error("enable set zero changed crystal enable");

    a_xtal_irq: assert property (
        flags_r[`CSIF_BIT_XTAL] && en_r[`CSIF_BIT_XTAL] |-> irq_o)
        else $error("crystal ready request missing");

    a_xtal_masked: assert property (
        !en_r[`CSIF_BIT_XTAL] && (flags_r & en_r) == 32'h0000_0000 |-> !irq_o)
        else $error("masked crystal ready raised a request");

    a_enable_shared: assert property (
        s_xtal_cleared |=> !en_r[`CSIF_BIT_XTAL] ##0
        (rif.rd_addr != `CSIF_OFS_EN_SET || !rif.rd_data[`CSIF_BIT_XTAL]))
        else $error("enable clear not seen through enable set");

    a_xtal_sync: assert property (
        s_xtal_up |-> stab_r[`CSIF_BIT_XTAL] ##1 stab_r[`CSIF_BIT_XTAL])
        else $error("stable ready not taken after synchroniser");

    a_set_wins: assert property (
        (rise_w & clr_w) != 32'h0000_0000 |=>
        (flags_r & $past(rise_w) & $past(clr_w)) == ($past(rise_w) & $past(clr_w)))
        else $error("clear won over a coincident set");
endmodule
`default_nettype wire

// [test/csif_top_test.sv]
// self-checking bench of the clock event flag block
`timescale 1ns/10ps
`default_nettype none
`include "csif_regs.svh"
module csif_top_test
    import csif_pkg::*;
;
    logic                    ref_clk, arst_n, irq_o;
    logic [`CSIF_STAT_W-1:0] power_clock_status, fuse_flag_preset;
    logic                    s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic                    s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
    logic                    s_axil_rvalid, s_axil_rready;
    logic [`CSIF_AW-1:0]     s_axil_awaddr, s_axil_araddr;
    csif_word_t              s_axil_wdata, s_axil_rdata;
    logic [3:0]              s_axil_wstrb;
    csif_resp_t              s_axil_bresp, s_axil_rresp;
    int                      errors, compares, cycles;

    csif_top u_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .power_clock_status(power_clock_status),
        .fuse_flag_preset(fuse_flag_preset), .irq_o(irq_o),
        .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
        .s_axil_awaddr(s_axil_awaddr), .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready), .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb), .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready), .s_axil_bresp(s_axil_bresp),
        .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
        .s_axil_araddr(s_axil_araddr), .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready), .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp)
    );

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // handshakes judged on values settled before the edge, released just after it
    task automatic axi_write(input logic [7:0] a, input csif_word_t d, output csif_resp_t r);
        logic aw_p, w_p, done, hs_aw, hs_w, hs_b;
        aw_p = 1'b1;
        w_p = 1'b1;
        done = 1'b0;
        s_axil_awaddr  <= a;
        s_axil_wdata   <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid  <= 1'b1;
        while (!done) begin
            @(negedge ref_clk);
            hs_aw = aw_p & s_axil_awready;
            hs_w = w_p & s_axil_wready;
            hs_b = s_axil_bvalid;
            r = s_axil_bresp;
            @(posedge ref_clk);
            if (hs_aw) begin
                aw_p = 1'b0;
                s_axil_awvalid <= 1'b0;
            end
            if (hs_w) begin
                w_p = 1'b0;
                s_axil_wvalid <= 1'b0;
            end
            done = hs_b;
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output csif_word_t d, output csif_resp_t r);
        logic ar_p, done;
        ar_p = 1'b1;
        done = 1'b0;
        s_axil_araddr  <= a;
        s_axil_arvalid <= 1'b1;
        while (!done) begin
            @(negedge ref_clk);
            done = s_axil_rvalid;
            d = s_axil_rdata;
            r = s_axil_rresp;
            if (ar_p & s_axil_arready) begin
                ar_p = 1'b0;
                @(posedge ref_clk);
                s_axil_arvalid <= 1'b0;
            end else begin
                @(posedge ref_clk);
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input csif_word_t d);
        csif_resp_t r;
        axi_write(a, d, r);
        check("write resp", {30'h0, r}, {30'h0, `CSIF_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input csif_word_t exp, input string what);
        csif_word_t d;
        csif_resp_t r;
        axi_read(a, d, r);
        check("read resp", {30'h0, r}, {30'h0, `CSIF_RESP_OKAY});
        check(what, d, exp);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge ref_clk);
        check("irq", {31'h0, irq_o}, {31'h0, exp});
    endtask

    task automatic do_reset(input logic [`CSIF_STAT_W-1:0] preset);
        arst_n <= 1'b0;
        fuse_flag_preset <= preset;
        power_clock_status <= '0;
        repeat (5) @(posedge ref_clk);
        check("irq in reset", {31'h0, irq_o}, 32'h0);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // expected flags after one edge of rises and write-one clears, set winning
    function automatic csif_word_t flag_next(input csif_word_t f, input csif_word_t rise,
                                             input csif_word_t clr);
        return ((f & ~clr) | rise) & `CSIF_IMPL_MASK;
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        csif_word_t v, exp_f, exp_en, d;
        csif_resp_t r;
        errors = 0;
        compares = 0;
        cycles = 0;
        arst_n = 1'b0;
        power_clock_status = '0;
        fuse_flag_preset = '0;
        s_axil_awvalid = 1'b0;
        s_axil_wvalid = 1'b0;
        s_axil_arvalid = 1'b0;
        s_axil_awaddr = '0;
        s_axil_araddr = '0;
        s_axil_wdata = '0;
        s_axil_wstrb = 4'hf;
        s_axil_bready = 1'b1;
        s_axil_rready = 1'b1;
        void'($urandom(8103));
        @(posedge ref_clk);
        do_reset('0);
        rd_chk(`CSIF_OFS_FLAGS, `CSIF_FLAGS_RST, "flags reset");
        rd_chk(`CSIF_OFS_EN_SET, `CSIF_EN_RST, "enables reset");
        // enables: set, zero write, clear, set again
        exp_en = $urandom & `CSIF_IMPL_MASK & 32'hffff_fffe;
        wr(`CSIF_OFS_EN_SET, exp_en);
        wr(`CSIF_OFS_EN_SET, 32'h0);
        rd_chk(`CSIF_OFS_EN_CLR, exp_en, "enables via clear");
        v = $urandom & `CSIF_IMPL_MASK;
        wr(`CSIF_OFS_EN_CLR, v);
        exp_en = exp_en & ~v;
        rd_chk(`CSIF_OFS_EN_SET, exp_en, "enables after clear");
        v = $urandom & `CSIF_IMPL_MASK & 32'hffff_fffe;
        wr(`CSIF_OFS_EN_SET, v);
        exp_en = exp_en | v;
        rd_chk(`CSIF_OFS_EN_SET, exp_en, "enables after set");
        // one status pulse per bit, reserved bits included
        exp_f = '0;
        for (int i = 0; i < `CSIF_STAT_W; i++) begin
            power_clock_status <= 18'h1 << i;
            repeat (6) @(posedge ref_clk);
            power_clock_status <= '0;
            repeat (6) @(posedge ref_clk);
            exp_f = flag_next(exp_f, 32'h1 << i, 32'h0);
            rd_chk(`CSIF_OFS_FLAGS, exp_f, "flag from rise");
            check("irq or", {31'h0, irq_o}, {31'h0, |(exp_f & exp_en)});
        end
        // crystal ready flag alone, enable off then on
        wr(`CSIF_OFS_FLAGS, `CSIF_IMPL_MASK & 32'hffff_fffe);
        wr(`CSIF_OFS_FLAGS, 32'h0);
        rd_chk(`CSIF_OFS_FLAGS, 32'h1, "zero write keeps");
        wr(`CSIF_OFS_EN_CLR, `CSIF_IMPL_MASK);
        irq_chk(1'b0);
        // byte lane 0 masked off: the set must not land
        s_axil_wstrb <= 4'he;
        wr(`CSIF_OFS_EN_SET, 32'h1);
        s_axil_wstrb <= 4'hf;
        rd_chk(`CSIF_OFS_EN_SET, 32'h0, "strobe masked set");
        irq_chk(1'b0);
        wr(`CSIF_OFS_EN_SET, 32'h1);
        irq_chk(1'b1);
        wr(`CSIF_OFS_FLAGS, 32'h1);
        irq_chk(1'b0);
        // many rises at once, then a random clear pattern through the alias
        v = $urandom;
        power_clock_status <= v[`CSIF_STAT_W-1:0];
        repeat (8) @(posedge ref_clk);
        exp_f = flag_next(32'h0, v, 32'h0);
        rd_chk(`CSIF_OFS_FLAGS, exp_f, "flags together");
        rd_chk(`CSIF_OFS_STATUS, v & `CSIF_IMPL_MASK, "status view");
        v = $urandom & `CSIF_IMPL_MASK;
        wr(`CSIF_OFS_FCLR, v);
        exp_f = flag_next(exp_f, 32'h0, v);
        power_clock_status <= '0;
        repeat (8) @(posedge ref_clk);
        rd_chk(`CSIF_OFS_FLAGS, exp_f, "partial clear");
        check("irq bit0", {31'h0, irq_o}, {31'h0, exp_f[0]});
        // status rise and write-one clear of the same flag land on one edge
        power_clock_status <= 18'h00004;
        repeat (2) @(posedge ref_clk);
        wr(`CSIF_OFS_FLAGS, 32'h4);
        exp_f = flag_next(exp_f, 32'h4, 32'h4);
        rd_chk(`CSIF_OFS_FLAGS, exp_f, "set beats clear");
        // unmapped address
        axi_read(8'h20, d, r);
        check("unmapped rresp", {30'h0, r}, {30'h0, `CSIF_RESP_SLVERR});
        check("unmapped rdata", d, 32'h0);
        axi_write(8'h20, $urandom, r);
        check("unmapped bresp", {30'h0, r}, {30'h0, `CSIF_RESP_SLVERR});
        // startup presets
        v = $urandom;
        do_reset(v[`CSIF_STAT_W-1:0]);
        rd_chk(`CSIF_OFS_FLAGS, v & `CSIF_IMPL_MASK, "fuse preset");
        check("irq preset", {31'h0, irq_o}, 32'h0);
        wr(`CSIF_OFS_FLAGS, v & `CSIF_IMPL_MASK);
        rd_chk(`CSIF_OFS_FLAGS, 32'h0, "preset cleared");
        wrap_up();
    end
endmodule
`default_nettype wire
